/* shared/bldcp_pkg.sv */
// Purpose: shared constants and carrier types of the commutation block
// Assumes: 125 MHz system clock, 32-bit register bus words
// Notes:   timing counts are derived from their time and the clock rate; register reset times are literal oscillator ticks
package bldcp_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ     = 125;
  localparam int OSC_HZ      = 43000;
  // internal oscillator period in clock cycles
  localparam int OSC_DIV     = (CLK_MHZ * 1000000) / OSC_HZ;
  localparam int BLANK_NS    = 700;
  // least time, rounded up
  localparam int BLANK_CYC   = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int OC_TRIG_NS  = 3000;
  localparam int OC_TRIG_CYC = (OC_TRIG_NS * CLK_MHZ + 999) / 1000;
  localparam int RETRY_MS    = 11;
  localparam int RETRY_CYC   = RETRY_MS * CLK_MHZ * 1000;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  REG_LOCK = 8'h00;
  localparam logic [7:0]  REG_SAVE = 8'h04;
  localparam logic [7:0]  REG_STAT = 8'h08;
  // about 2 s of oscillator ticks
  localparam logic [23:0] LOCK_RST = 24'h014FF0;
  // about 10 ms of oscillator ticks
  localparam logic [23:0] SAVE_RST = 24'h0001AE;
  // status bit positions
  localparam int ST_LOCKED = 0;
  localparam int ST_OCOFF  = 1;
  localparam int ST_THERM  = 2;
  localparam int ST_UV     = 3;
  localparam int ST_HFAULT = 4;
  localparam int ST_ZERO   = 5;
  localparam int ST_LIMIT  = 6;
  localparam int ST_CAPGND = 7;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // bit 0 is phase a, bit 2 is phase c
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } bldcp_drive_t;

  typedef struct packed {
    logic [11:0]  osc_cnt;
    logic         dir_prev;
    logic [2:0]   hall_prev;
    logic [23:0]  lock_cnt;
    logic         locked;
    logic [20:0]  retry;
    logic         oc_off;
    logic         thermal;
    logic         limit;
    logic [6:0]   blank;
    logic         bias;
    bldcp_drive_t drv;
  } bldcp_core_t;

  typedef struct packed {
    logic [23:0] lock_time;
    logic [23:0] save_time;
    logic [7:0]  addr;
    logic        wr;
    logic [31:0] rdata;
  } bldcp_ahb_t;

endpackage

/* hw/bldcp_persist.sv */
// Purpose: flags a condition that has held for a number of steps
// Assumes: step is a one-cycle strobe, or tied high to count clocks
// Notes:   the count restarts whenever the condition drops
module bldcp_persist #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         cond,
  input  wire logic         step,
  input  wire logic [W-1:0] limit,
  output logic              hit
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         hit;
  } bldcp_cnt_t;

  bldcp_cnt_t st_reg;
  bldcp_cnt_t st_next;

  if (W < 1 || W > 32) begin : g_chk
    $error("bldcp_persist: W out of range");
  end

  // count held steps, saturate on the flag
  always_comb begin
    st_next = st_reg;
    if (!cond) begin
      st_next.cnt = '0;
      st_next.hit = 1'b0;
    end else if (step && !st_reg.hit) begin
      st_next.cnt = st_reg.cnt + W'(1);
      if (st_reg.cnt + W'(1) >= limit) begin
        st_next.hit = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hit = st_reg.hit;

endmodule // bldcp_persist

/* hw/bldcp_ahb_slave.sv */
// Purpose: register slave on the system bus, zero wait states
// Assumes: single word transfers; response always OKAY
// Notes:   read data is captured in the address phase
module bldcp_ahb_slave (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [7:0]  status,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [23:0]      lock_time,
  output logic [23:0]      save_time
);

  bldcp_pkg::bldcp_ahb_t st_reg;
  bldcp_pkg::bldcp_ahb_t st_next;
  logic                  aphase;
  logic                  mapped;

  assign aphase = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:8] == 24'h000000);

  // address phase latches, data phase writes
  always_comb begin
    st_next = st_reg;
    st_next.wr = 1'b0;
    if (st_reg.wr) begin
      case (st_reg.addr)
        bldcp_pkg::REG_LOCK: st_next.lock_time = hwdata[23:0];
        bldcp_pkg::REG_SAVE: st_next.save_time = hwdata[23:0];
        default: st_next.wr = 1'b0;
      endcase
    end
    if (aphase) begin
      st_next.addr  = mapped ? haddr[7:0] : 8'hFF;
      st_next.wr    = hwrite && (hsize == 3'h2);
      st_next.rdata = 32'h00000000;
      if (!hwrite && mapped) begin
        case (haddr[7:0])
          bldcp_pkg::REG_LOCK: st_next.rdata = {8'h00, st_reg.lock_time};
          bldcp_pkg::REG_SAVE: st_next.rdata = {8'h00, st_reg.save_time};
          bldcp_pkg::REG_STAT: st_next.rdata = {24'h000000, status};
          default:             st_next.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{lock_time: bldcp_pkg::LOCK_RST,
                  save_time: bldcp_pkg::SAVE_RST,
                  addr: 8'h00, wr: 1'b0, rdata: 32'h00000000};
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata    = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign lock_time = st_reg.lock_time;
  assign save_time = st_reg.save_time;

endmodule // bldcp_ahb_slave

/* hw/bldcp_commutation.sv */
// Purpose: commutation, drive and protection logic of a 3-phase driver
// Assumes: comparator and pin inputs synchronous to CLK
// Notes:   phase drives are registered, one cycle behind their causes
//
// Added by the designer: the AHB-Lite register port and the address map.

module bldcp_commutation #(
  parameter int RETRY_CYCLES = bldcp_pkg::RETRY_CYC
) (
  input  wire logic             CLK,
  input  wire logic             ARST_N,
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  input  wire logic             HALL_INPUT_A,
  input  wire logic             HALL_INPUT_B,
  input  wire logic             HALL_INPUT_C,
  input  wire logic             DIRECTION,
  input  wire logic             BRAKE,
  input  wire logic             SLEEP,
  input  wire logic             SPEED_ON_N,
  input  wire logic             UV_THRESHOLD_SELECT,
  input  wire logic             UV_CMP_LOW,
  input  wire logic             UV_CMP_HIGH,
  input  wire logic             LOCK_TIMER_CAP_GND,
  input  wire logic             OVER_TEMP_HOT,
  input  wire logic             OVER_TEMP_COOL,
  input  wire logic             CURRENT_LIMIT,
  input  wire logic             OVERCURRENT,
  output bldcp_pkg::bldcp_drive_t PHASE_OUTPUT,
  output logic                  HALL_BIAS_SUPPLY,
  output logic                  TRI_HALL_SPEED_OUT,
  output logic                  SINGLE_HALL_SPEED_OUT
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  bldcp_pkg::bldcp_core_t st_reg;
  bldcp_pkg::bldcp_core_t st_next;
  logic [2:0]  hall;
  logic [2:0]  pat;
  logic [2:0]  src;
  logic [2:0]  snk;
  logic [7:0]  status;
  logic [23:0] lock_time;
  logic [23:0] save_time;
  logic        osc_tick;
  logic        uv;
  logic        hall_fault;
  logic        init_rst;
  logic        lock_clr;
  logic        hall_chg;
  logic        run;
  logic        drive_on;
  logic        zero_duty;
  logic        oc_hit;
  logic        sense_ok;

  if (RETRY_CYCLES < 1 || RETRY_CYCLES >= 2 ** 21) begin : g_chk
    $error("bldcp_commutation: RETRY_CYCLES out of range");
  end

  // ****************************************************************
  // register slave and persistence timers
  // ****************************************************************
  bldcp_ahb_slave u_regs (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hsize     (HSIZE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .status    (status),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .lock_time (lock_time),
    .save_time (save_time)
  );

  bldcp_persist #(.W(24)) u_zero (
    .clk    (CLK),
    .arst_n (ARST_N),
    .cond   (SPEED_ON_N && SLEEP),
    .step   (osc_tick),
    .limit  (save_time),
    .hit    (zero_duty)
  );

  bldcp_persist #(.W(9)) u_oc (
    .clk    (CLK),
    .arst_n (ARST_N),
    .cond   (OVERCURRENT && !st_reg.oc_off),
    .step   (1'b1),
    .limit  (9'(bldcp_pkg::OC_TRIG_CYC)),
    .hit    (oc_hit)
  );

  // ****************************************************************
  // decode of pins and comparators
  // ****************************************************************
  // direction low inverts pattern
  assign hall = {HALL_INPUT_A, HALL_INPUT_B, HALL_INPUT_C};
  assign pat  = DIRECTION ? hall : ~hall;

  always_comb begin
    case (pat)
      3'h5: begin src = 3'h2; snk = 3'h1; end
      3'h4: begin src = 3'h4; snk = 3'h1; end
      3'h6: begin src = 3'h4; snk = 3'h2; end
      3'h2: begin src = 3'h1; snk = 3'h2; end
      3'h3: begin src = 3'h1; snk = 3'h4; end
      3'h1: begin src = 3'h2; snk = 3'h4; end
      default: begin src = 3'h0; snk = 3'h0; end
    endcase
  end

  assign TRI_HALL_SPEED_OUT    = HALL_INPUT_A ^ HALL_INPUT_B ^ HALL_INPUT_C;
  assign SINGLE_HALL_SPEED_OUT = !HALL_INPUT_A;

  assign uv = SLEEP && (UV_THRESHOLD_SELECT ? UV_CMP_HIGH : UV_CMP_LOW);
  assign hall_fault = (hall == 3'h0) || (hall == 3'h7);
  assign init_rst = !SLEEP || BRAKE || uv || LOCK_TIMER_CAP_GND;
  assign lock_clr = init_rst || (DIRECTION != st_reg.dir_prev) || zero_duty;
  assign hall_chg = (hall != st_reg.hall_prev);
  assign osc_tick = (st_reg.osc_cnt == 12'(bldcp_pkg::OSC_DIV - 1));
  assign sense_ok = (st_reg.blank == 7'h00);
  // drive on while speed input low and current limit clear
  assign drive_on = !SPEED_ON_N && !st_reg.limit;
  assign run = SLEEP && !uv && !st_reg.thermal && !hall_fault &&
               !st_reg.oc_off && !LOCK_TIMER_CAP_GND && !zero_duty;

  // status view for software
  always_comb begin
    status = 8'h00;
    status[bldcp_pkg::ST_LOCKED] = st_reg.locked;
    status[bldcp_pkg::ST_OCOFF]  = st_reg.oc_off;
    status[bldcp_pkg::ST_THERM]  = st_reg.thermal;
    status[bldcp_pkg::ST_UV]     = uv;
    status[bldcp_pkg::ST_HFAULT] = hall_fault;
    status[bldcp_pkg::ST_ZERO]   = zero_duty;
    status[bldcp_pkg::ST_LIMIT]  = st_reg.limit;
    status[bldcp_pkg::ST_CAPGND] = LOCK_TIMER_CAP_GND;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.osc_cnt = osc_tick ? 12'h000 : st_reg.osc_cnt + 12'h001;
    st_next.dir_prev  = DIRECTION;
    st_next.hall_prev = hall;

    if (OVER_TEMP_HOT) begin
      st_next.thermal = 1'b1;
    end else if (OVER_TEMP_COOL) begin
      st_next.thermal = 1'b0;
    end

    if (lock_clr) begin
      st_next.lock_cnt = 24'h000000;
      st_next.locked   = 1'b0;
    end else if (hall_chg) begin
      st_next.lock_cnt = 24'h000000;
    end else if (osc_tick && !st_reg.thermal && !st_reg.locked) begin
      st_next.lock_cnt = st_reg.lock_cnt + 24'h000001;
      if (st_reg.lock_cnt + 24'h000001 >= lock_time) begin
        st_next.locked = 1'b1;
      end
    end

    if (init_rst) begin
      st_next.oc_off = 1'b0;
      st_next.retry  = 21'h000000;
    end else if (st_reg.oc_off) begin
      st_next.retry = st_reg.retry + 21'h000001;
      if (st_reg.retry == 21'(RETRY_CYCLES - 1)) begin
        st_next.oc_off = 1'b0;
        st_next.retry  = 21'h000000;
      end
    end else if (oc_hit) begin
      st_next.oc_off = 1'b1;
      st_next.retry  = 21'h000000;
    end

    // chop until next tick, set wins
    if (!run) begin
      st_next.limit = 1'b0;
    end else if (CURRENT_LIMIT && sense_ok && st_reg.drv.ls != 3'h0) begin
      st_next.limit = 1'b1;
    end else if (osc_tick) begin
      st_next.limit = 1'b0;
    end

    // phase drive from state and pins
    st_next.drv = '0;
    if (run) begin
      if (BRAKE) begin
        st_next.drv.ls = 3'h7;
      end else begin
        // on phase sources, off phase recirculates high
        st_next.drv.hs = st_reg.locked ? 3'h0 :
                         (drive_on ? src : (src | snk));
        st_next.drv.ls = drive_on ? snk : 3'h0;
      end
    end

    if (st_next.drv != st_reg.drv) begin
      st_next.blank = 7'(bldcp_pkg::BLANK_CYC);
    end else if (st_reg.blank != 7'h00) begin
      st_next.blank = st_reg.blank - 7'h01;
    end

    st_next.bias = SLEEP && !zero_duty;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PHASE_OUTPUT     = st_reg.drv;
  assign HALL_BIAS_SUPPLY = st_reg.bias;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  brake_lower_sides_a: assert property (
    (run && BRAKE) |=> (PHASE_OUTPUT.ls == 3'h7 && PHASE_OUTPUT.hs == 3'h0))
    else $error("brake does not short the lower sides");

  speed_off_phase_a: assert property (
    (run && !BRAKE && SPEED_ON_N) |=> (PHASE_OUTPUT.ls == 3'h0))
    else $error("lower side on while speed input high");

  sync_rectify_a: assert property (
    (run && !BRAKE && SPEED_ON_N && !st_reg.locked && src != 3'h0)
      |=> ($countones(PHASE_OUTPUT.hs) == 2))
    else $error("off phase does not freewheel high");

  limit_cuts_a: assert property (
    (st_reg.limit && run && !BRAKE) |=> (PHASE_OUTPUT.ls == 3'h0))
    else $error("limit did not cut the on duty");

  blank_holds_a: assert property (
    (st_reg.blank != 7'h00 && !st_reg.limit) |=> !st_reg.limit)
    else $error("current limit set inside blanking");

  oc_outputs_off_a: assert property (
    (oc_hit && !init_rst && !st_reg.oc_off)
      ##1 st_reg.oc_off |=> (PHASE_OUTPUT == '0) [*3])
    else $error("outputs on during overcurrent shutdown");

  zero_bias_off_a: assert property (
    zero_duty |=> !HALL_BIAS_SUPPLY)
    else $error("hall bias on at zero duty");

  lock_upper_off_a: assert property (
    st_reg.locked |=> (PHASE_OUTPUT.hs == 3'h0))
    else $error("upper side on while locked");

  lock_release_a: assert property (
    lock_clr |=> (!st_reg.locked && st_reg.lock_cnt == 24'h000000))
    else $error("lock not released");

  thermal_hold_a: assert property (
    (st_reg.thermal && !lock_clr && !hall_chg) |=> $stable(st_reg.lock_cnt))
    else $error("lock count moved during thermal stop");

  fault_all_off_a: assert property (
    (hall_fault || uv || !SLEEP) |=> (PHASE_OUTPUT == '0))
    else $error("outputs on during fault or sleep");

endmodule // bldcp_commutation

/* dv/bldcp_host_model.sv */
// Purpose: host side pulse source for the active-low speed input
// Assumes: lengths change only while the train is steady
// Notes:   zero off length holds drive on, zero on length holds it off
module bldcp_host_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] on_len,
  input  wire logic [7:0] off_len,
  output logic            speed_on_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_reg;

  // ****************************************************************
  // pulse train
  // ****************************************************************
  // duty sets speed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg    <= 8'h00;
      speed_on_n <= 1'h1;  // drive off until the host starts
    end else if (off_len == 8'h00) begin
      speed_on_n <= 1'h0;
    end else if (on_len == 8'h00) begin
      speed_on_n <= 1'h1;
    end else if (cnt_reg == 8'h00) begin
      speed_on_n <= ~speed_on_n;
      cnt_reg    <= (speed_on_n ? on_len : off_len) - 8'h01;
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule // bldcp_host_model

/* dv/bldcp_commutation_test.sv */
// Purpose: self-checking bench of the commutation and protection block
// Assumes: retry shortened to 50 cycles, lock and save times rewritten
// Notes:   drive checks sample at the falling edge, after the drive register; register reads sample at the rising edge
module bldcp_commutation_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICK = 2906;
  logic clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [2:0] hall = 3'h5;
  logic dir = 1'h0, brake = 1'h0, sleep = 1'h1, uv_sel = 1'h0;
  logic uv_low = 1'h0, uv_high = 1'h0, cap_gnd = 1'h0, hot = 1'h0;
  logic cool = 1'h0, cur_lim = 1'h0, oc = 1'h0;
  logic hready, hresp, speed, bias, tri_fg, one_fg, s, seen;
  logic [7:0] on_len = 8'h00, off_len = 8'h00;
  logic [2:0] pats [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  bldcp_pkg::bldcp_drive_t phase;
  int failures = 0, compares = 0;

  // free-running clock, 8 ns
  always #4 clk = ~clk;

  bldcp_host_model i_host (.clk(clk), .arst_n(arst_n), .on_len(on_len),
    .off_len(off_len), .speed_on_n(speed));

  bldcp_commutation #(.RETRY_CYCLES(50)) i_dut (.CLK(clk),
    .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .HALL_INPUT_A(hall[2]), .HALL_INPUT_B(hall[1]),
    .HALL_INPUT_C(hall[0]), .DIRECTION(dir), .BRAKE(brake),
    .SLEEP(sleep), .SPEED_ON_N(speed), .UV_THRESHOLD_SELECT(uv_sel),
    .UV_CMP_LOW(uv_low), .UV_CMP_HIGH(uv_high),
    .LOCK_TIMER_CAP_GND(cap_gnd), .OVER_TEMP_HOT(hot),
    .OVER_TEMP_COOL(cool), .CURRENT_LIMIT(cur_lim),
    .OVERCURRENT(oc), .PHASE_OUTPUT(phase), .HALL_BIAS_SUPPLY(bias),
    .TRI_HALL_SPEED_OUT(tri_fg), .SINGLE_HALL_SPEED_OUT(one_fg));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // expected drive from halls, direction and on/off phase
  function automatic bldcp_pkg::bldcp_drive_t exp_drv(logic [2:0] h,
      logic d, logic on);
    logic [5:0] ss;
    bldcp_pkg::bldcp_drive_t e;
    case (d ? h : ~h)
      3'h5:    ss = 6'h11;
      3'h4:    ss = 6'h21;
      3'h6:    ss = 6'h22;
      3'h2:    ss = 6'h0A;
      3'h3:    ss = 6'h0C;
      3'h1:    ss = 6'h14;
      default: ss = 6'h00;
    endcase
    e.hs = on ? ss[5:3] : (ss[5:3] | ss[2:0]);
    e.ls = on ? ss[2:0] : 3'h0;
    return e;
  endfunction

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic drv_chk(input logic on);
    chk(32'(phase), 32'(exp_drv(hall, dir, on)));
  endtask

  // one single transfer; the wait on ready is bounded
  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'h1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'h0, a, 32'h0, x);
    chk(x, e);
  endtask

  task automatic st_chk(input int b, input logic v);
    logic [31:0] x;
    ahb(1'h0, bldcp_pkg::REG_STAT, 32'h0, x);
    chk(32'(x[b]), 32'(v));
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    chk(32'(phase), 32'h0);
    chk({bias, hready, hresp}, 32'h2);
    arst_n <= 1'h1;
    rd_chk(bldcp_pkg::REG_LOCK, {8'h0, bldcp_pkg::LOCK_RST});
    rd_chk(bldcp_pkg::REG_SAVE, {8'h0, bldcp_pkg::SAVE_RST});
    rd_chk(8'h0C, 32'h0);
    wr(bldcp_pkg::REG_LOCK, 32'hFF12_3456);
    rd_chk(bldcp_pkg::REG_LOCK, 32'h0012_3456);
    // all six valid hall states in both directions
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge clk);
        dir  <= d[0];
        hall <= pats[i];
        settle(2);
        drv_chk(1'h1);
        chk(32'(tri_fg), 32'(^hall));
        chk(32'(one_fg), 32'(!hall[2]));
        chk(32'(bias), 32'h1);
      end
    end
    @(posedge clk);
    off_len <= 8'h01;
    settle(2);
    drv_chk(1'h0);
    @(posedge clk);
    on_len  <= 8'd20;
    off_len <= 8'd30;
    settle(4);
    // drive follows the pulse train one cycle behind
    for (int i = 0; i < 200; i++) begin
      s = speed;
      @(negedge clk);
      drv_chk(!s);
    end
    @(posedge clk);
    off_len <= 8'h00;
    brake   <= 1'h1;
    settle(2);
    chk(32'(phase), 32'h07);
    @(posedge clk);
    brake <= 1'h0;
    hall  <= 3'h0;
    settle(2);
    chk(32'(phase), 32'h0);
    @(posedge clk);
    hall <= 3'h7;
    settle(2);
    chk(32'(phase), 32'h0);
    @(posedge clk);
    hall <= 3'h1;
    // only the selected comparator stops the drive
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      uv_sel  <= k[1];
      uv_low  <= ~k[0];
      uv_high <= k[0];
      settle(2);
      chk(32'(phase == 6'h0), 32'(k[1] == k[0]));
    end
    @(posedge clk);
    uv_high <= 1'h0;
    cap_gnd <= 1'h1;
    settle(2);
    chk(32'(phase), 32'h0);
    @(posedge clk);
    cap_gnd <= 1'h0;
    sleep   <= 1'h0;
    settle(2);
    chk({phase, bias}, 32'h0);
    @(posedge clk);
    sleep <= 1'h1;
    hot   <= 1'h1;
    settle(1);
    @(posedge clk);
    hot <= 1'h0;
    settle(2);
    chk(32'(phase), 32'h0);
    st_chk(bldcp_pkg::ST_THERM, 1'h1);
    @(posedge clk);
    cool <= 1'h1;
    settle(2);
    drv_chk(1'h1);
    @(posedge clk);
    cool <= 1'h0;
    oc   <= 1'h1;
    settle(370);
    drv_chk(1'h1);
    settle(10);
    chk(32'(phase), 32'h0);
    @(posedge clk);
    oc <= 1'h0;
    settle(20);
    chk(32'(phase), 32'h0);
    settle(60);
    drv_chk(1'h1);
    // a limit right after a drive change is ignored while blanked
    @(posedge clk);
    hall    <= 3'h3;
    cur_lim <= 1'h1;
    settle(60);
    drv_chk(1'h1);
    seen = 1'h0;
    for (int i = 0; i < 40; i++) begin
      settle(0);
      if (phase === exp_drv(hall, dir, 1'h0)) begin
        seen = 1'h1;
      end
    end
    chk(32'(seen), 32'h1);
    @(posedge clk);
    cur_lim <= 1'h0;
    settle(TICK + 10);
    drv_chk(1'h1);
    wr(bldcp_pkg::REG_SAVE, 32'h3);
    // a zero on length holds the speed input high, no pulses
    @(posedge clk);
    on_len  <= 8'h00;
    off_len <= 8'h01;
    settle(5 * TICK);
    chk({phase, bias}, 32'h0);
    st_chk(bldcp_pkg::ST_ZERO, 1'h1);
    @(posedge clk);
    off_len <= 8'h00;
    // zero flag is registered, drive returns one cycle later
    settle(3);
    drv_chk(1'h1);
    wr(bldcp_pkg::REG_SAVE, {8'h0, bldcp_pkg::SAVE_RST});
    wr(bldcp_pkg::REG_LOCK, 32'h3);
    settle(5 * TICK);
    chk(32'(phase.hs), 32'h0);
    st_chk(bldcp_pkg::ST_LOCKED, 1'h1);
    @(posedge clk);
    dir <= ~dir;
    settle(2);
    st_chk(bldcp_pkg::ST_LOCKED, 1'h0);
    settle(5 * TICK);
    st_chk(bldcp_pkg::ST_LOCKED, 1'h1);
    @(posedge clk);
    brake <= 1'h1;
    settle(2);
    st_chk(bldcp_pkg::ST_LOCKED, 1'h0);
    finish_test();
  end
endmodule // bldcp_commutation_test
